/* i2c_byte_source.sv */
// Far-side sender: one received byte per link clock rise.
// Assumes the link clock stands still between frames.
`timescale 1ns/100ps
module i2c_byte_source (
  input wire logic i_clk, // System clock
  input wire logic i_link_clk, // Link clock
  output logic o_byte // One-cycle byte pulse
);
  logic [1:0] sync_reg = 2'h0;
  logic byte_reg = 1'b0;
  assign o_byte = byte_reg;
  // Falling edge so the pulse is settled at the sampling edge
  always @(negedge i_clk) begin
    sync_reg <= {sync_reg[0], i_link_clk};
    byte_reg <= sync_reg == 2'h1;
  end
endmodule

/* i2c_fifo_status.sv */
// FIFO status flags and threshold registers of the I2C controller.
// Assumes FIFO levels, strobes and idle/enable signals arrive from logic on i_clk.
//
// Behaviour
// - Transmit overflow bit 3 sets on a command write while transmit FIFO holds 32.
// - Overflow and underflow flags hold while disabled, clear when internal enable is 0.
// - Receive full bit 2 follows level at or above receive threshold.
// - Enable bit low flushes and holds the receive FIFO; receive full clears at once.
// - Receive overflow bit 1 sets when a byte arrives with receive FIFO holding 32.
// - An overflowing byte is still acknowledged but discarded, never stored.
// - Receive underflow bit 0 sets on a data read while receive FIFO is empty.
// - Receive threshold bits 4:0 read/write; larger writes store the maximum depth.
// - Receive threshold means stored value plus one entry.
// - Transmit threshold bits 4:0 read/write; larger writes store the maximum depth.
// - Transmit threshold is a direct entry count; 31 means 32 entries.
// - Transmit empty bit 4 set while enabled and level is at or below transmit threshold; while disabled it follows i_fsm_active.
// - Transmit empty clears as soon as level rises above the threshold.
`timescale 1ns/100ps

module i2c_fifo_status #(
  parameter int DEPTH = 32,
  parameter int LEVEL_W = 6
) (
  input wire logic i_clk,                       // System clock
  input wire logic i_sys_rst,                   // Async reset, active high
  input wire logic [31:0] i_reg_addr,           // Register byte address
  input wire logic i_reg_wr,                    // Register write strobe
  input wire logic i_reg_rd,                    // Register read strobe
  input wire logic [15:0] i_reg_wdata,          // Register write data
  output logic [15:0] o_reg_rdata,              // Register read data
  input wire logic i_enable,                    // Enable bit from control register
  input wire logic i_internal_enable,           // Internal enable, drops after idle
  input wire logic i_fsm_active,                // Master or slave machine not idle
  input wire logic [LEVEL_W-1:0] i_tx_level,    // Transmit FIFO fill level
  input wire logic [LEVEL_W-1:0] i_rx_level,    // Receive FIFO fill level
  input wire logic i_data_command_port_wr,      // Processor write to data/command port
  input wire logic i_data_command_port_rd,      // Processor read of data/command port
  input wire logic i_rx_byte,                   // Byte received from the bus
  output logic o_rx_store,                      // Push received byte into FIFO
  output logic o_rx_ack,                        // Acknowledge received byte
  output logic o_rx_flush,                      // Hold receive FIFO in reset
  output i2c_fifo_status_pkg::raw_flags_s o_raw_flags, // Raw status flags
  output logic [4:0] o_rx_thresh,               // Stored receive threshold
  output logic [4:0] o_tx_thresh                // Stored transmit threshold
);

  // ==========================================================
  // Parameter check
  // Flag and threshold coding is fixed to a 32-entry FIFO
  if (DEPTH != 32 || LEVEL_W < 6) begin : g_param_check
    $error("i2c_fifo_status: DEPTH must be 32 and LEVEL_W at least 6");
  end

  // ==========================================================
  // State
  i2c_fifo_status_pkg::status_state_s state_reg;
  i2c_fifo_status_pkg::status_state_s state_next;

  localparam logic [LEVEL_W-1:0] FULL_LEVEL = LEVEL_W'(DEPTH);
  localparam int STICKY_N = 3;

  // ==========================================================
  // Address decode
  logic sel_raw;
  logic sel_rx_thresh;
  logic sel_tx_thresh;
  logic rx_thresh_wr;
  logic tx_thresh_wr;

  // Unmapped reads fall to the zero default of the read mux
  assign sel_raw = (i_reg_addr == i2c_fifo_status_pkg::RAW_STATUS_ADDR);
  assign sel_rx_thresh = (i_reg_addr == i2c_fifo_status_pkg::RX_THRESH_ADDR);
  assign sel_tx_thresh = (i_reg_addr == i2c_fifo_status_pkg::TX_THRESH_ADDR);
  // Raw status is read only, so a write there has no target
  assign rx_thresh_wr = i_reg_wr && sel_rx_thresh;
  assign tx_thresh_wr = i_reg_wr && sel_tx_thresh;

  // ==========================================================
  // Write data clamp
  logic wdata_over;
  logic [4:0] wr_clamped;

  // Whole word compared: a set reserved bit also saturates
  assign wdata_over = (i_reg_wdata > 16'(i2c_fifo_status_pkg::THRESH_MAX));
  // Over-range writes saturate rather than wrap
  assign wr_clamped = wdata_over ? i2c_fifo_status_pkg::THRESH_MAX :
                      i_reg_wdata[i2c_fifo_status_pkg::THRESH_MSB:0];

  // ==========================================================
  // FIFO level conditions
  logic rx_is_full;
  logic rx_is_empty;
  logic tx_is_full;
  logic [LEVEL_W-1:0] rx_trig;
  logic [LEVEL_W-1:0] tx_trig;
  logic rx_at_trig;
  logic tx_at_trig;

  // Levels above the depth are treated as full
  assign rx_is_full = (i_rx_level >= FULL_LEVEL);
  assign rx_is_empty = (i_rx_level == '0);
  assign tx_is_full = (i_tx_level >= FULL_LEVEL);
  // Stored value plus one entry
  assign rx_trig = LEVEL_W'(state_reg.rx_thresh) + LEVEL_W'(1);
  // Top code stands for a full FIFO
  assign tx_trig = (state_reg.tx_thresh == i2c_fifo_status_pkg::THRESH_MAX) ?
                   FULL_LEVEL : LEVEL_W'(state_reg.tx_thresh);
  assign rx_at_trig = (i_rx_level >= rx_trig);
  assign tx_at_trig = (i_tx_level <= tx_trig);

  // ==========================================================
  // Level-following flags
  logic rx_full_cond;
  logic tx_empty_cond;

  // Flushed receive FIFO is never full, whatever the bus does
  assign rx_full_cond = i_enable && rx_at_trig;
  // Flushed transmit FIFO looks empty only while machines still run
  assign tx_empty_cond = i_enable ? tx_at_trig : i_fsm_active;

  // ==========================================================
  // Sticky error flags
  // Bit 0 receive underflow, bit 1 receive overflow, bit 2 transmit overflow
  // No clear-on-read here: only internal enable low or reset clears them
  logic [STICKY_N-1:0] sticky_event;
  logic [STICKY_N-1:0] sticky_old;
  logic [STICKY_N-1:0] sticky_new;

  assign sticky_event[0] = i_data_command_port_rd && rx_is_empty;
  assign sticky_event[1] = i_rx_byte && rx_is_full;
  assign sticky_event[2] = i_data_command_port_wr && tx_is_full;
  assign sticky_old = {state_reg.flags.tx_over, state_reg.flags.rx_over,
                       state_reg.flags.rx_under};

  // A set in the clearing cycle wins, so no event is lost
  for (genvar i = 0; i < STICKY_N; i++) begin : g_sticky
    logic keep;
    assign keep = sticky_old[i] && i_internal_enable;
    assign sticky_new[i] = sticky_event[i] || keep;
  end

  // ==========================================================
  // Read data
  logic [15:0] raw_word;
  logic [15:0] rx_thresh_word;
  logic [15:0] tx_thresh_word;
  logic [15:0] read_word;

  // Reserved upper bits are tied low
  assign raw_word = {11'h000, state_reg.flags};
  assign rx_thresh_word = {11'h000, state_reg.rx_thresh};
  assign tx_thresh_word = {11'h000, state_reg.tx_thresh};

  always_comb begin
    read_word = i2c_fifo_status_pkg::REG_ZERO;
    if (sel_raw) begin
      read_word = raw_word;
    end else if (sel_rx_thresh) begin
      read_word = rx_thresh_word;
    end else if (sel_tx_thresh) begin
      read_word = tx_thresh_word;
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    state_next = state_reg;

    // Threshold registers
    if (rx_thresh_wr) begin
      state_next.rx_thresh = wr_clamped;
    end
    if (tx_thresh_wr) begin
      state_next.tx_thresh = wr_clamped;
    end

    // Status flags
    state_next.flags.tx_over = sticky_new[2];
    state_next.flags.rx_over = sticky_new[1];
    state_next.flags.rx_under = sticky_new[0];
    state_next.flags.rx_full = rx_full_cond;
    state_next.flags.tx_empty = tx_empty_cond;

    // Read word is captured here and held until the next read
    if (i_reg_rd) begin
      state_next.rdata = read_word;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg.rx_thresh <= i2c_fifo_status_pkg::THRESH_RESET;
      state_reg.tx_thresh <= i2c_fifo_status_pkg::THRESH_RESET;
      state_reg.flags.tx_empty <= 1'b0;
      state_reg.flags.tx_over <= 1'b0;
      state_reg.flags.rx_full <= 1'b0;
      state_reg.flags.rx_over <= 1'b0;
      state_reg.flags.rx_under <= 1'b0;
      state_reg.rdata <= i2c_fifo_status_pkg::REG_ZERO;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Receive path and outputs
  logic rx_keep;

  // Nothing is pushed into a full or flushed FIFO
  assign rx_keep = i_rx_byte && !rx_is_full && i_enable;
  // Extra byte is acknowledged on the bus even when it cannot be kept
  assign o_rx_ack = i_rx_byte;
  assign o_rx_store = rx_keep;
  assign o_rx_flush = !i_enable;
  assign o_reg_rdata = state_reg.rdata;
  assign o_raw_flags = state_reg.flags;
  assign o_rx_thresh = state_reg.rx_thresh;
  assign o_tx_thresh = state_reg.tx_thresh;

endmodule

/* i2c_fifo_status_monitor.sv */
// Port-level checks for the FIFO status flag block.
// Assumes binding onto i2c_fifo_status, all signals on i_clk.
`timescale 1ns/100ps
module i2c_fifo_status_monitor #(parameter int LEVEL_W = 6) (
  input wire logic i_clk, // Clock
  input wire logic i_sys_rst, // Reset
  input wire logic i_enable, // Enable bit
  input wire logic i_internal_enable, // Internal enable
  input wire logic [LEVEL_W-1:0] i_tx_level, // Tx level
  input wire logic [LEVEL_W-1:0] i_rx_level, // Rx level
  input wire logic i_data_command_port_wr, // Port write
  input wire logic i_data_command_port_rd, // Port read
  input wire logic i_rx_byte, // Byte in
  input wire logic o_rx_store, // Store
  input wire logic o_rx_ack, // Ack
  input wire logic o_rx_flush, // Flush
  input wire i2c_fifo_status_pkg::raw_flags_s o_raw_flags, // Flags
  input wire logic [4:0] o_rx_thresh // Rx threshold
);
  // ====
  // Checks
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_ack_always: assert property (o_rx_ack == i_rx_byte) else $error("byte not acked");
  a_store_room: assert property (
    o_rx_store == (i_rx_byte && i_enable && i_rx_level < 32)) else $error("bad store");
  a_flush_off: assert property (o_rx_flush == !i_enable) else $error("bad flush");
  a_full_level: assert property (1 |=> o_raw_flags.rx_full ==
    $past(i_enable && i_rx_level > o_rx_thresh)) else $error("bad rx full");
  a_tx_over_set: assert property (i_data_command_port_wr && i_tx_level == 32 |=>
    o_raw_flags.tx_over) else $error("tx over missed");
  a_rx_over_set: assert property (i_rx_byte && i_rx_level == 32 |=>
    o_raw_flags.rx_over) else $error("rx over missed");
  a_rx_under_set: assert property (i_data_command_port_rd && i_rx_level == 0 |=>
    o_raw_flags.rx_under) else $error("rx under missed");
  a_sticky_clear: assert property (!i_internal_enable && !i_rx_byte |=>
    !o_raw_flags.rx_over) else $error("rx over kept");
  a_sticky_hold: assert property (i_internal_enable && o_raw_flags.rx_under |=>
    o_raw_flags.rx_under) else $error("rx under lost");
endmodule
bind i2c_fifo_status i2c_fifo_status_monitor #(.LEVEL_W(LEVEL_W)) u_mon (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_enable(i_enable),
  .i_internal_enable(i_internal_enable), .i_tx_level(i_tx_level), .i_rx_level(i_rx_level),
  .i_data_command_port_wr(i_data_command_port_wr),
  .i_data_command_port_rd(i_data_command_port_rd), .i_rx_byte(i_rx_byte),
  .o_rx_store(o_rx_store), .o_rx_ack(o_rx_ack), .o_rx_flush(o_rx_flush),
  .o_raw_flags(o_raw_flags), .o_rx_thresh(o_rx_thresh)
);

/* i2c_fifo_status_pkg.sv */
// Constants and carrier types for the FIFO status and threshold block.
// Assumes the enclosing controller supplies FIFO levels and strobes on i_clk.
package i2c_fifo_status_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [31:0] RAW_STATUS_ADDR = 32'h50001334;
  localparam logic [31:0] RX_THRESH_ADDR = 32'h50001338;
  localparam logic [31:0] TX_THRESH_ADDR = 32'h5000133c;

  // ==========================================================
  // Field positions and reset values
  localparam int RAW_RX_UNDER_BIT = 0;
  localparam int RAW_RX_OVER_BIT = 1;
  localparam int RAW_RX_FULL_BIT = 2;
  localparam int RAW_TX_OVER_BIT = 3;
  localparam int RAW_TX_EMPTY_BIT = 4;
  localparam int THRESH_MSB = 4;
  localparam logic [4:0] THRESH_RESET = 5'h00;
  localparam logic [4:0] THRESH_MAX = 5'h1f;
  localparam logic [15:0] REG_ZERO = 16'h0000;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic tx_empty;
    logic tx_over;
    logic rx_full;
    logic rx_over;
    logic rx_under;
  } raw_flags_s;

  typedef struct packed {
    logic [4:0] rx_thresh;
    logic [4:0] tx_thresh;
    raw_flags_s flags;
    logic [15:0] rdata;
  } status_state_s;

endpackage

/* tb.sv */
// Random bench with a cycle model of flags, thresholds and read data.
// Assumes i2c_fifo_status and i2c_byte_source are compiled first.
`timescale 1ns/100ps
module tb;
  logic i_clk = 0, i_sys_rst = 1, lk = 0, fr = 0, w = 0, r = 0, en = 0, ie = 0;
  logic fa = 0, dw = 0, dr = 0, rb, st, ak, fl;
  logic [1:0] k = 0;
  logic [31:0] s, s2, map [4];
  logic [15:0] wd = 0, rd, e_rd;
  logic [5:0] tl = 0, rl = 0;
  logic [4:0] rth, tth, e_rt, e_tt, e_f;
  i2c_fifo_status_pkg::raw_flags_s fo;
  int bad_count = 0, comparisons = 0, seed = 47966, cyc = 0;
  i2c_fifo_status u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(map[k]),
    .i_reg_wr(w), .i_reg_rd(r), .i_reg_wdata(wd), .o_reg_rdata(rd), .i_enable(en),
    .i_internal_enable(ie), .i_fsm_active(fa), .i_tx_level(tl), .i_rx_level(rl),
    .i_data_command_port_wr(dw), .i_data_command_port_rd(dr), .i_rx_byte(rb),
    .o_rx_store(st), .o_rx_ack(ak), .o_rx_flush(fl), .o_raw_flags(fo),
    .o_rx_thresh(rth), .o_tx_thresh(tth));
  i2c_byte_source u_src (.i_clk(i_clk), .i_link_clk(lk), .o_byte(rb));
  // ====
  // Clocks, model and checks
  always #10 i_clk = ~i_clk;
  initial begin
    #3;
    forever #80 lk = fr & ~lk;
  end
  task chk(input string n, input logic [15:0] v, input logic [15:0] e);
    comparisons++;
    if (v !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, v);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Model reads old thresholds before this edge's write lands
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) {e_f, e_rt, e_tt, e_rd} = 0;
    else begin
      if (r) e_rd = k == 0 ? {11'h0, e_f} : k == 1 ? {11'h0, e_rt} : k == 2 ? {11'h0, e_tt} : 0;
      e_f = {en ? tl <= (e_tt == 5'h1f ? 6'h20 : {1'b0, e_tt}) : fa, dw && tl == 6'h20 ||
        e_f[3] && ie, en && rl > e_rt, rb && rl == 6'h20 || e_f[1] && ie, dr && rl == 0 ||
        e_f[0] && ie};
      if (w && k == 1) e_rt = wd > 31 ? 5'h1f : wd[4:0];
      if (w && k == 2) e_tt = wd > 31 ? 5'h1f : wd[4:0];
    end
  end
  always @(negedge i_clk) begin
    chk("flags", 16'(fo), 16'(e_f));
    chk("rdata", rd, e_rd);
    chk("thresh", {6'h0, rth, tth}, {6'h0, e_rt, e_tt});
    chk("rxpath", {13'h0, st, ak, fl}, {13'h0, rb && rl < 32 && en, rb, !en});
    s = $random(seed);
    s2 = $random(seed);
    k <= s[1:0];
    w <= s[2];
    r <= s[3];
    en <= s[6:4] != 0;
    ie <= s[9:7] != 0;
    fa <= s[10];
    dw <= s[11];
    dr <= s[12];
    wd <= s[13] ? s[31:16] : {10'h0, s[19:14]};
    if (s[30:26] == 0) fr <= ~fr;
    tl <= 6'(s2[15:0] % 16'h21);
    rl <= 6'(s2[31:16] % 16'h21);
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    map = '{i2c_fifo_status_pkg::RAW_STATUS_ADDR, i2c_fifo_status_pkg::RX_THRESH_ADDR,
      i2c_fifo_status_pkg::TX_THRESH_ADDR, 32'h50001340};
    repeat (2) @(negedge i_clk);
    i_sys_rst <= 0;
    repeat (2000) @(negedge i_clk);
    // Second reset mid-run; late update keeps the negedge checks race free
    i_sys_rst <= 1;
    @(negedge i_clk);
    i_sys_rst <= 0;
    repeat (2000) @(negedge i_clk);
    report_and_stop();
  end
endmodule
